// file: src/ccu_pkg.sv
// Constants for the codec port upper control block: register map, field
// positions, reset values and the bit-clock timing derived from aclk.
// Assumes a 250 MHz aclk and a 32-bit AXI4-Lite register bus.
package ccu_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  ISTAT_OFS    = 8'h04;
  localparam logic [7:0]  IMASK_OFS    = 8'h08;
  localparam logic [7:0]  AUX_OFS      = 8'h0C;
  localparam logic [7:0]  STAT_OFS     = 8'h10;

  // ----------------------------------------------------------------------
  // Main control field positions
  // ----------------------------------------------------------------------
  localparam int          B_EN         = 16;
  localparam int          B_CS         = 17;
  localparam int          B_ADM        = 18;
  localparam int          B_TTE        = 19;
  localparam int          B_TRE        = 20;
  localparam int          B_ATE        = 21;
  localparam int          B_ARE        = 22;
  localparam int          B_LBM        = 23;
  localparam int          B_ECP        = 24;
  localparam int          ECP_W        = 2;
  localparam logic [31:0] CTRL_WMASK   = 32'h03FF_0000;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  // Auxiliary register: frequency select of the second control register.
  localparam int          B_FS         = 0;
  localparam logic [31:0] AUX_RST      = 32'h0000_0000;

  // Interrupt status and mask layout, one bit per FIFO service request.
  localparam int          NIRQ         = 4;
  localparam int          I_TTX        = 0;
  localparam int          I_TRX        = 1;
  localparam int          I_ATX        = 2;
  localparam int          I_ARX        = 3;
  localparam logic [3:0]  IMASK_RST    = 4'h0;

  // ----------------------------------------------------------------------
  // Bit clock and frame timing
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          BCLK_FAST_PS  = 83466;
  localparam int          BCLK_SLOW_PS  = 104329;
  localparam int          FAST_CYC      = BCLK_FAST_PS / CLK_PERIOD_PS;
  localparam int          SLOW_CYC      = BCLK_SLOW_PS / CLK_PERIOD_PS;
  localparam logic [4:0]  FAST_M1       = 5'(FAST_CYC - 1);
  localparam logic [4:0]  SLOW_M1       = 5'(SLOW_CYC - 1);
  localparam logic [4:0]  FRAME_M1      = 5'h1F;

  // ----------------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : ccu_pkg

// file: src/ccu_div.sv
// Tick divider: emits a one-cycle pulse on every (div_m1+1)-th input tick.
// Assumes tick_in is a one-cycle pulse on aclk.
`timescale 1ns/1ns
`default_nettype none

module ccu_div #(
  parameter int W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         clr,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div_m1,
  output var  logic         tick_out
);

  logic [W-1:0] cnt_q;

  // Count input ticks; a clear restarts the count so a new setting takes
  // effect from a clean phase.
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_q >= div_m1) begin
          cnt_q    <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule : ccu_div

`default_nettype wire

// file: src/ccu_ctrl.sv
// Codec port upper control block: control register, interrupt gating,
// pin handover, clock source and prescaler, frame and sample timing.
// Assumes FIFO service flags, receive-valid flags and the serial shifter
// output arrive on aclk; the external clock and receive pin are async.
`timescale 1ns/1ns
`default_nettype none

module ccu_ctrl #(
  parameter int SDIV_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic              irq,
  input  wire logic              tel_tx_service,
  input  wire logic              tel_rx_service,
  input  wire logic              aud_tx_service,
  input  wire logic              aud_rx_service,
  output var  logic [3:0]        service_irq,
  input  wire logic              sync_port_enable,
  input  wire logic              sync_port_remap,
  output var  logic              sync_port_grant,
  output var  logic              port_active,
  output var  logic              pins_to_pin_controller,
  input  wire logic              ext_clk_in,
  input  wire logic              link_rx_i,
  output var  logic              link_tx_o,
  output var  logic              link_tx_oe,
  output var  logic              link_sclk_o,
  output var  logic              link_sclk_oe,
  output var  logic              link_frame_o,
  output var  logic              link_frame_oe,
  input  wire logic              shifter_tx,
  output var  logic              shifter_rx,
  output var  logic              bit_tick,
  output var  logic              frame_tick,
  input  wire logic [SDIV_W-1:0] aud_sample_div,
  input  wire logic [SDIV_W-1:0] tel_sample_div,
  input  wire logic              aud_rx_valid,
  input  wire logic              tel_rx_valid,
  output var  logic              aud_rx_store,
  output var  logic              tel_rx_store
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Merge a write into an old value under the byte strobes.
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // A divisor of zero is treated as one so the counter never stalls.
  function automatic logic [SDIV_W-1:0] sdiv_m1(input logic [SDIV_W-1:0] d);
    return (d == '0) ? '0 : d - 1'b1;
  endfunction : sdiv_m1

  // Receive store decision for one channel.
  function automatic logic rx_store(input logic rx_sampling_mode, input logic armed,
                                    input logic valid, input logic tmo);
    return (rx_sampling_mode && armed) ? tmo : valid;
  endfunction : rx_store

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0]      ctrl_q;
  logic [31:0]      aux_q;
  logic [3:0]       istat_q;
  logic [3:0]       imask_q;
  logic             aw_full_q;
  logic             w_full_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             aw_take;
  logic             w_take;
  logic             ar_take;
  logic             wr_do;
  logic             wr_hit;
  logic [31:0]      w1c;
  logic             en;
  logic             cs;
  logic             rx_sampling_mode;
  logic             loopback;
  logic             handover;
  logic [3:0]       svc_gated;
  logic [3:0]       svc_prev_q;
  logic [3:0]       ev;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             ext_s3_q;
  logic             rx_s1_q;
  logic             rx_s2_q;
  logic             ext_edge;
  logic             presc_tick;
  logic [4:0]       int_cnt_q;
  logic             int_tick_q;
  logic             bit_t;
  logic             aud_tmo;
  logic             tel_tmo;
  logic             aud_armed_q;
  logic             tel_armed_q;
  logic [31:0]      rd_val;

  assign en       = ctrl_q[ccu_pkg::B_EN];
  assign cs       = ctrl_q[ccu_pkg::B_CS];
  assign rx_sampling_mode      = ctrl_q[ccu_pkg::B_ADM];
  assign loopback      = ctrl_q[ccu_pkg::B_LBM];

  assign handover = !en || loopback;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_do   = aw_full_q && w_full_q && !s_axi_bvalid;
  assign w1c     = strb_merge(32'h0000_0000, wdata_q, wstrb_q);

  // Address and data are held separately so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_full_q     <= aw_take || (aw_full_q && !wr_do);
      w_full_q      <= w_take || (w_full_q && !wr_do);
      s_axi_awready <= !(aw_take || (aw_full_q && !wr_do));
      s_axi_wready  <= !(w_take || (w_full_q && !wr_do));
    end
  end

  // Write response follows one cycle after both halves are held.
  always_comb begin
    case (awaddr_q)
      ccu_pkg::CTRL_OFS, ccu_pkg::ISTAT_OFS, ccu_pkg::IMASK_OFS,
      ccu_pkg::AUX_OFS, ccu_pkg::STAT_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ccu_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control, mask and auxiliary registers; status writes are read-only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= ccu_pkg::CTRL_RST;
      aux_q   <= ccu_pkg::AUX_RST;
      imask_q <= ccu_pkg::IMASK_RST;
    end else if (wr_do) begin
      if (awaddr_q == ccu_pkg::CTRL_OFS) begin
        ctrl_q <= strb_merge(ctrl_q, wdata_q, wstrb_q) & ccu_pkg::CTRL_WMASK;
      end
      if (awaddr_q == ccu_pkg::AUX_OFS) begin
        aux_q <= {31'h0000_0000, w1c[ccu_pkg::B_FS]};
      end
      if (awaddr_q == ccu_pkg::IMASK_OFS) begin
        imask_q <= wstrb_q[0] ? wdata_q[3:0] : imask_q;
      end
    end
  end

  // Read path: one cycle from address taken to data valid.
  always_comb begin
    case (s_axi_araddr)
      ccu_pkg::CTRL_OFS:  rd_val = ctrl_q;
      ccu_pkg::ISTAT_OFS: rd_val = {28'h000_0000, istat_q};
      ccu_pkg::IMASK_OFS: rd_val = {28'h000_0000, imask_q};
      ccu_pkg::AUX_OFS:   rd_val = aux_q;
      ccu_pkg::STAT_OFS:  rd_val = {26'h000_0000, cs, tel_armed_q, aud_armed_q,
                                    sync_port_grant, pins_to_pin_controller,
                                    port_active};
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ccu_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= (s_axi_araddr > ccu_pkg::STAT_OFS ||
                         s_axi_araddr[1:0] != 2'h0) ?
                        ccu_pkg::RESP_SLVERR : ccu_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt gating and sticky status
  // ----------------------------------------------------------------------

  assign svc_gated[ccu_pkg::I_TTX] = tel_tx_service && ctrl_q[ccu_pkg::B_TTE];
  assign svc_gated[ccu_pkg::I_TRX] = tel_rx_service && ctrl_q[ccu_pkg::B_TRE];
  assign svc_gated[ccu_pkg::I_ATX] = aud_tx_service && ctrl_q[ccu_pkg::B_ATE];
  assign svc_gated[ccu_pkg::I_ARX] = aud_rx_service && ctrl_q[ccu_pkg::B_ARE];
  assign ev = svc_gated & ~svc_prev_q;

  // A new request in the clear cycle survives: set wins over clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_prev_q  <= 4'h0;
      service_irq <= 4'h0;
      istat_q     <= 4'h0;
      irq         <= 1'b0;
    end else begin
      svc_prev_q  <= svc_gated;
      service_irq <= svc_gated;
      if (wr_do && awaddr_q == ccu_pkg::ISTAT_OFS) begin
        istat_q <= (istat_q & ~w1c[3:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
      irq <= |(istat_q & imask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Pin handover and port precedence
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_active            <= 1'b0;
      pins_to_pin_controller <= 1'b1;
      sync_port_grant        <= 1'b0;
    end else begin
      port_active            <= en;
      pins_to_pin_controller <= handover;
      sync_port_grant        <= sync_port_enable && (!en || sync_port_remap);
    end
  end

  // ----------------------------------------------------------------------
  // Clock source, prescaler and frame timing
  // ----------------------------------------------------------------------

  // Pin inputs pass two flops; the receive pin feeds logic from the second, the clock edge detect from the second and a third.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      rx_s1_q  <= 1'b0;
      rx_s2_q  <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      rx_s1_q  <= link_rx_i;
      rx_s2_q  <= rx_s1_q;
    end
  end

  assign ext_edge = ext_s2_q && !ext_s3_q && en && cs;

  ccu_div #(.W(ccu_pkg::ECP_W)) u_presc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (!en || !cs),
    .tick_in  (ext_edge),
    .div_m1   (ctrl_q[ccu_pkg::B_ECP +: ccu_pkg::ECP_W]),
    .tick_out (presc_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !en || cs) begin
      int_cnt_q  <= 5'h00;
      int_tick_q <= 1'b0;
    end else if (int_cnt_q >= (aux_q[ccu_pkg::B_FS] ? ccu_pkg::SLOW_M1
                                                    : ccu_pkg::FAST_M1)) begin
      int_cnt_q  <= 5'h00;
      int_tick_q <= 1'b1;
    end else begin
      int_cnt_q  <= int_cnt_q + 5'h01;
      int_tick_q <= 1'b0;
    end
  end

  assign bit_t = cs ? presc_tick : int_tick_q;

  ccu_div #(.W(5)) u_frame (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (!en),
    .tick_in  (bit_t),
    .div_m1   (ccu_pkg::FRAME_M1),
    .tick_out (frame_tick)
  );

  ccu_div #(.W(SDIV_W)) u_aud_sr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (!en),
    .tick_in  (frame_tick),
    .div_m1   (sdiv_m1(aud_sample_div)),
    .tick_out (aud_tmo)
  );

  ccu_div #(.W(SDIV_W)) u_tel_sr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (!en),
    .tick_in  (frame_tick),
    .div_m1   (sdiv_m1(tel_sample_div)),
    .tick_out (tel_tmo)
  );

  // ----------------------------------------------------------------------
  // Receive store timing
  // ----------------------------------------------------------------------

  always_ff @(posedge aclk) begin
    if (!aresetn || !en || !rx_sampling_mode) begin
      aud_armed_q <= 1'b0;
      tel_armed_q <= 1'b0;
    end else begin
      aud_armed_q <= aud_armed_q || aud_rx_valid;
      tel_armed_q <= tel_armed_q || tel_rx_valid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aud_rx_store <= 1'b0;
      tel_rx_store <= 1'b0;
    end else begin
      aud_rx_store <= en && rx_store(rx_sampling_mode, aud_armed_q, aud_rx_valid, aud_tmo);
      tel_rx_store <= en && rx_store(rx_sampling_mode, tel_armed_q, tel_rx_valid, tel_tmo);
    end
  end

  // ----------------------------------------------------------------------
  // Link pins and serial shifter path
  // ----------------------------------------------------------------------

  // The bit clock toggles per bit tick, so one link clock period spans
  // two ticks; frame pulses line up with the low half.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_tick      <= 1'b0;
      link_sclk_o   <= 1'b0;
      link_tx_o     <= 1'b0;
      link_frame_o  <= 1'b0;
      link_tx_oe    <= 1'b0;
      link_sclk_oe  <= 1'b0;
      link_frame_oe <= 1'b0;
      shifter_rx    <= 1'b0;
    end else begin
      bit_tick      <= bit_t;
      link_sclk_o   <= en && (bit_t ? !link_sclk_o : link_sclk_o);
      link_tx_o     <= shifter_tx && !handover;
      link_frame_o  <= frame_tick && !handover;
      link_tx_oe    <= !handover;
      link_sclk_oe  <= !handover;
      link_frame_oe <= !handover;
      shifter_rx    <= loopback ? shifter_tx : rx_s2_q;
    end
  end

endmodule : ccu_ctrl

`default_nettype wire

// file: tb/ccu_codec_model.sv
// Codec-side model: external bit clock and the receive data line.
// Assumes the block drives link_tx_o and link_tx_oe; link_rx has a pull-up.
`timescale 1ns/1ns
`default_nettype none
module ccu_codec_model #(
  parameter int HALF_NS = 44
) (
  input  wire logic run,
  input  wire logic link_tx_o,
  input  wire logic link_tx_oe,
  output var  logic ext_clk_in,
  output var  logic link_rx_i
);
  // divided clock limit
  // An 88 ns period keeps even the undivided clock under 12 MHz; it rests low
  // while not running.
  initial ext_clk_in = 1'b0;
  always begin
    #(HALF_NS);
    ext_clk_in = run ? ~ext_clk_in : 1'b0;
  end
  // The codec echoes the inverted transmit bit; a released line floats high.
  assign link_rx_i = link_tx_oe ? ~link_tx_o : 1'b1;
endmodule : ccu_codec_model
`default_nettype wire

// file: tb/ccu_ctrl_monitor.sv
// Port checker for the codec port upper control block, bound to ccu_ctrl.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ccu_ctrl_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       tel_tx_service,
  input wire logic       tel_rx_service,
  input wire logic       aud_tx_service,
  input wire logic       aud_rx_service,
  input wire logic [3:0] service_irq,
  input wire logic       sync_port_enable,
  input wire logic       sync_port_remap,
  input wire logic       sync_port_grant,
  input wire logic       port_active,
  input wire logic       pins_to_pin_controller,
  input wire logic       link_tx_oe,
  input wire logic       shifter_tx,
  input wire logic       shifter_rx,
  input wire logic       bit_tick,
  input wire logic       frame_tick
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] bt_q;
  logic       seen_q;
  // Bit ticks since the last frame; the first frame after enable is not checked.
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_active) begin
      bt_q   <= 8'h00;
      seen_q <= 1'b0;
    end else if (frame_tick) begin
      bt_q   <= 8'h00;
      seen_q <= 1'b1;
    end else if (bit_tick) begin
      bt_q <= bt_q + 8'h01;
    end
  end
  a_pins_off: assert property ($stable(port_active) && !port_active |->
    pins_to_pin_controller) else $error("pins kept while port off");
  a_oe_handover: assert property (link_tx_oe == !pins_to_pin_controller)
    else $error("output enable disagrees with handover");
  a_sync_grant: assert property ($past(aresetn) && $stable(port_active) |->
    sync_port_grant == $past(sync_port_enable && (!port_active || sync_port_remap)))
    else $error("sync port grant wrong");
  a_service_gate: assert property ($past(aresetn) |-> (service_irq & ~$past(
    {aud_rx_service, aud_tx_service, tel_rx_service, tel_tx_service})) == 4'h0)
    else $error("service interrupt without service");
  a_loop_wrap: assert property (port_active && pins_to_pin_controller &&
    $past(port_active && pins_to_pin_controller) |-> shifter_rx == $past(shifter_tx))
    else $error("loopback data lost");
  a_frame_bits: assert property (frame_tick && seen_q |->
    8'(bt_q + 8'(bit_tick)) == 8'h20) else $error("frame is not 32 bit ticks");
  a_bit_gap: assert property (bit_tick |=> (!bit_tick) [*4])
    else $error("bit ticks too close");
  a_idle_port: assert property ((!port_active) [*3] |-> !bit_tick && !frame_tick)
    else $error("timing runs while port off");
  c_frame: cover property (frame_tick && seen_q);
  c_service: cover property (|service_irq);
  c_grant: cover property (sync_port_grant && port_active);
endmodule : ccu_ctrl_monitor
bind ccu_ctrl ccu_ctrl_monitor u_mon (.*);
`default_nettype wire

// file: tb/test_codec_port_control_upper.sv
// Self-checking bench for the codec port upper control block.
// Assumes ccu_ctrl on a 250 MHz aclk and the codec model on the pins.
`timescale 1ns/1ns
`default_nettype none
module test_codec_port_control_upper;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'h0, service_irq;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, shifter_tx = 1'b0;
  logic tel_tx_service = 1'b0, tel_rx_service = 1'b0;
  logic aud_tx_service = 1'b0, aud_rx_service = 1'b0;
  logic sync_port_enable = 1'b0, sync_port_remap = 1'b0;
  logic aud_rx_valid = 1'b0, tel_rx_valid = 1'b0;
  logic [7:0] aud_sample_div = 8'h01, tel_sample_div = 8'h01;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, sync_port_grant, port_active, pins_to_pin_controller, ext_clk_in;
  logic link_rx_i, link_tx_o, link_tx_oe, link_sclk_o, link_sclk_oe;
  logic link_frame_o, link_frame_oe, shifter_rx, bit_tick, frame_tick;
  logic aud_rx_store, tel_rx_store;
  logic [31:0] seed = 32'h0000_002D;
  int mismatches = 0, n_checks = 0, c, i;
  ccu_ctrl uut (.*);
  ccu_codec_model u_codec (.*);
  // Free-running 250 MHz clock.
  always #2 aclk = ~aclk;
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic to();
    mismatches++;
    $display("CHECK FAILED at %0t: no answer", $time);
    test_done();
  endtask : to
  // Write with address and data offered together; the response is compared.
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e = ccu_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64 && !(s_axi_bvalid && s_axi_bready); n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 64) to();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(e));
  endtask : wchk
  task automatic rchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e = ccu_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64 && !(s_axi_rvalid && s_axi_rready); n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 64) to();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(e));
  endtask : rchk
  // Cycles between ticks; the first two spans may hold an old setting.
  task automatic gap(input logic f, output int k);
    for (int m = 0; m < 3; m++) begin
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!(f ? frame_tick : bit_tick) && k < 4000);
    end
    if (k >= 4000) to();
  endtask : gap
  task automatic vp(input logic [31:0] e);
    @(posedge aclk);
    aud_rx_valid <= 1'b1;
    tel_rx_valid <= 1'b1;
    @(posedge aclk);
    aud_rx_valid <= 1'b0;
    tel_rx_valid <= 1'b0;
    @(posedge aclk);
    chk({30'h0, aud_rx_store, tel_rx_store}, e);
  endtask : vp
  // Main sequence.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(ccu_pkg::STAT_OFS, 32'h0000_0002);
    rchk(ccu_pkg::AUX_OFS, ccu_pkg::AUX_RST);
    rchk(8'h14, 32'h0000_0000, ccu_pkg::RESP_SLVERR);
    wchk(8'h20, 32'hFFFF_FFFF, ccu_pkg::RESP_SLVERR);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      r = (i == 0) ? 32'hFFFF_FFFF : seed;
      wchk(ccu_pkg::CTRL_OFS, r);
      rchk(ccu_pkg::CTRL_OFS, r & ccu_pkg::CTRL_WMASK);
      wchk(ccu_pkg::ISTAT_OFS, 32'h0000_000F);
      wchk(ccu_pkg::IMASK_OFS, 32'(r[3:0]));
      {aud_rx_service, aud_tx_service, tel_rx_service, tel_tx_service} <= r[7:4];
      repeat (4) @(posedge aclk);
      chk(32'(service_irq), 32'(r[22:19] & r[7:4]));
      rchk(ccu_pkg::ISTAT_OFS, 32'(r[22:19] & r[7:4]));
      chk(32'(irq), 32'(|(r[22:19] & r[7:4] & r[3:0])));
      {aud_rx_service, aud_tx_service, tel_rx_service, tel_tx_service} <= 4'h0;
      wchk(ccu_pkg::ISTAT_OFS, 32'h0000_000F);
      rchk(ccu_pkg::ISTAT_OFS, 32'h0000_0000);
    end
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      sync_port_enable <= 1'b1;
      sync_port_remap <= i[1];
      shifter_tx <= seed[0];
      wchk(ccu_pkg::CTRL_OFS, {8'h00, i[2], 6'h00, i[0], 16'h0000});
      repeat (4) @(posedge aclk);
      chk(32'(pins_to_pin_controller), 32'(!i[0] | i[2]));
      chk(32'(sync_port_grant), 32'(!i[0] | i[1]));
      chk(32'({link_tx_oe, link_sclk_oe, link_frame_oe}), 32'({3{i[0] & !i[2]}}));
      chk(32'(shifter_rx), 32'(i[2] ? seed[0] : !(i[0] & seed[0])));
    end
    run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wchk(ccu_pkg::CTRL_OFS, 32'h0003_0000 | (32'(i) << 24));
      gap(1'b0, c);
      chk(32'(c), 32'(22 * (i + 1)));
    end
    run <= 1'b0;
    for (i = 0; i < 2; i++) begin
      wchk(ccu_pkg::AUX_OFS, 32'(i));
      wchk(ccu_pkg::CTRL_OFS, 32'h0301_0000);
      gap(1'b0, c);
      chk(32'(c), 32'(i ? ccu_pkg::SLOW_CYC : ccu_pkg::FAST_CYC));
    end
    gap(1'b1, c);
    chk(32'(c), 32'h0000_0340);
    wchk(ccu_pkg::CTRL_OFS, 32'h0001_0000);
    vp(32'h0000_0003);
    wchk(ccu_pkg::CTRL_OFS, 32'h0000_0000);
    aud_sample_div <= 8'h02;
    wchk(ccu_pkg::CTRL_OFS, 32'h0005_0000);
    vp(32'h0000_0003);
    vp(32'h0000_0000);
    c = 0;
    i = 0;
    repeat (1664) begin
      @(posedge aclk);
      c += aud_rx_store;
      i += tel_rx_store;
    end
    chk(32'(c), 32'h0000_0001);
    chk(32'(i), 32'h0000_0002);
    test_done();
  end
endmodule : test_codec_port_control_upper
`default_nettype wire
